/* File: rtl/sadc_consts.vh */
/*
  constants for the successive-approximation sequencer: register offsets,
  field positions, reset values and schedule counts.
  assumes inclusion by bare name from every sadc design file.
*/
`ifndef SADC_CONSTS_VH
`define SADC_CONSTS_VH

// bus widths
`define SADC_ADDR_W 8
`define SADC_DATA_W 32

// result width and bit index width
`define SADC_RES_W 10
`define SADC_BIDX_W 4

// register offsets (byte addresses, one word each)
`define SADC_OFF_STATUS 8'h00
`define SADC_OFF_RESULT 8'h04
`define SADC_OFF_TRIAL 8'h08
`define SADC_OFF_IRQ_STAT 8'h0C
`define SADC_OFF_IRQ_MASK 8'h10

// status register fields
`define SADC_STAT_DONE_BIT 0
`define SADC_STAT_BUSY_BIT 1

// trial register fields
`define SADC_TRIAL_CODE_LSB 0
`define SADC_TRIAL_BIDX_LSB 16
`define SADC_TRIAL_CYC_LSB 24

// interrupt events
`define SADC_EV_DONE 0
`define SADC_EV_OVERRUN 1
`define SADC_NUM_EV 2

// reset values
`define SADC_RESULT_RST 10'h000
`define SADC_MASK_RST 2'h0
`define SADC_DONE_RST 1'h1
`define SADC_DATA_ZERO 32'h0000_0000

// schedule: conversion length and per-trial slot
`define SADC_CONV_CYCLES 61
`define SADC_SLOT_CYCLES 6
`define SADC_SET_PHASE 3'h0
`define SADC_SAMPLE_PHASE 3'h5
`define SADC_TOP_BIDX 4'h9

`endif

/* File: rtl/sadc_trial_step.v */
/*
  one successive-approximation step on the trial code: raise the bit
  under test, or keep/clear it from the comparator decision.
  assumes bidx is within the result width; purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sadc_consts.vh"

module sadc_trial_step
(
  input wire [`SADC_RES_W-1:0] code,
  input wire [`SADC_BIDX_W-1:0] bidx,
  input wire set_bit,
  input wire decide,
  input wire cmp_below,
  output reg [`SADC_RES_W-1:0] code_next
);

  reg [`SADC_RES_W-1:0] onehot;

  always @*
  begin
    onehot = {{(`SADC_RES_W-1){1'b0}}, 1'b1} << bidx;
    code_next = code;
    if (set_bit)
    begin
      code_next = code | onehot; // [RULE_03] [RULE_06]
    end
    else if (decide && !cmp_below)
    begin
      code_next = code & ~onehot; // [RULE_04]
    end
  end

endmodule
`default_nettype wire

/* File: rtl/sadc_irq.v */
/*
  sticky interrupt status with mask and one level output.
  assumes events are one-cycle pulses; status cleared by writing ones.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sadc_consts.vh"

module sadc_irq
(
  input wire clk,
  input wire rst,
  input wire [`SADC_NUM_EV-1:0] event_set,
  input wire [`SADC_NUM_EV-1:0] status_clr,
  input wire mask_wr,
  input wire [`SADC_NUM_EV-1:0] mask_wdata,
  output wire [`SADC_NUM_EV-1:0] status,
  output reg [`SADC_NUM_EV-1:0] mask_q,
  output wire irq
);

  reg [`SADC_NUM_EV-1:0] status_q;

  genvar i;
  generate
    for (i = 0; i < `SADC_NUM_EV; i = i + 1)
    begin : g_ev
      // set beats a simultaneous clear
      always @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          status_q[i] <= 1'b0;
        end
        else if (event_set[i])
        begin
          status_q[i] <= 1'b1;
        end
        else if (status_clr[i])
        begin
          status_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mask_q <= `SADC_MASK_RST;
    end
    else if (mask_wr)
    begin
      mask_q <= mask_wdata;
    end
  end

  assign status = status_q;
  assign irq = |(status_q & mask_q);

endmodule
`default_nettype wire

/* File: rtl/sadc_sequencer.v */
/*
  successive-approximation conversion sequencer with register port.
  assumes an external comparator and reference ladder: trial_code sets the
  comparison voltage, cmp_below answers whether it lies below the input.
*/
// Functional notes
// [RULE_01] writing completion bit zero starts conversion
// [RULE_02] result register cleared at conversion start
// [RULE_03] first trial sets most significant bit
// [RULE_04] keep bit if below input, else clear
// [RULE_05] ten trials, down to least significant bit
// [RULE_06] higher bits keep decisions, next bit set
// [RULE_07] code n drives reference times n/1024
// [RULE_08] result stored 61 cycles after start
// [RULE_09] completion raises conversion interrupt request
// [RULE_10] software keeps oscillator at least 500 kHz
// [RULE_11] software avoids stop mode during conversion
// [RULE_12] completion bit returns to one when stored
// [RULE_13] comparator sampled once per trial slot
`timescale 1ns/1ps
`default_nettype none
`include "sadc_consts.vh"

module sadc_sequencer
(
  input wire clk,
  input wire rst,
  input wire [`SADC_ADDR_W-1:0] bus_addr,
  input wire [`SADC_DATA_W-1:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  output reg [`SADC_DATA_W-1:0] bus_rdata,
  input wire cmp_below,
  output wire [`SADC_RES_W-1:0] trial_code,
  output wire convert_active,
  output wire irq
);

  // sequencer states
  localparam [1:0] S_IDLE = 2'b00;
  localparam [1:0] S_TRIAL = 2'b01;
  localparam [1:0] S_STORE = 2'b10;

  // register select codes
  localparam [2:0] SEL_NONE = 3'd0;
  localparam [2:0] SEL_STATUS = 3'd1;
  localparam [2:0] SEL_RESULT = 3'd2;
  localparam [2:0] SEL_TRIAL = 3'd3;
  localparam [2:0] SEL_IRQ_STAT = 3'd4;
  localparam [2:0] SEL_IRQ_MASK = 3'd5;

  // schedule figures, cut to counter width on purpose
  localparam integer STORE_CYC_I = `SADC_CONV_CYCLES - 1;
  localparam integer LAST_PHASE_I = `SADC_SLOT_CYCLES - 1;
  localparam [5:0] STORE_CYC = STORE_CYC_I[5:0];
  localparam [2:0] LAST_PHASE = LAST_PHASE_I[2:0];

  // address decode, shared by read and write
  function [2:0] sel_of;
    input [`SADC_ADDR_W-1:0] a;
    begin
      case (a)
        `SADC_OFF_STATUS: sel_of = SEL_STATUS;
        `SADC_OFF_RESULT: sel_of = SEL_RESULT;
        `SADC_OFF_TRIAL: sel_of = SEL_TRIAL;
        `SADC_OFF_IRQ_STAT: sel_of = SEL_IRQ_STAT;
        `SADC_OFF_IRQ_MASK: sel_of = SEL_IRQ_MASK;
        default: sel_of = SEL_NONE;
      endcase
    end
  endfunction

  // trial-slot phase decode, shared by set and decide
  function in_phase;
    input [1:0] st;
    input [2:0] ph;
    input [2:0] want;
    begin
      in_phase = (st == S_TRIAL) && (ph == want);
    end
  endfunction

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [`SADC_RES_W-1:0] code_q;
  reg [`SADC_RES_W-1:0] result_q;
  reg [`SADC_RES_W-1:0] result_d;
  reg [`SADC_BIDX_W-1:0] bidx_q;
  reg [`SADC_BIDX_W-1:0] bidx_d;
  reg [2:0] phase_q;
  reg [2:0] phase_d;
  reg [5:0] cyc_q;
  reg [5:0] cyc_d;
  reg done_q;
  reg done_d;
  reg ev_done;
  reg ev_overrun;
  reg load_code;

  wire [2:0] wr_sel;
  wire [2:0] rd_sel;
  wire start_req;
  wire idle;
  wire set_bit;
  wire decide;
  wire [`SADC_RES_W-1:0] code_step;
  wire [`SADC_NUM_EV-1:0] irq_status;
  wire [`SADC_NUM_EV-1:0] irq_mask;
  wire [`SADC_NUM_EV-1:0] irq_clr;
  reg [`SADC_DATA_W-1:0] status_word;
  reg [`SADC_DATA_W-1:0] result_word;
  reg [`SADC_DATA_W-1:0] trial_word;
  reg [`SADC_DATA_W-1:0] irq_stat_word;
  reg [`SADC_DATA_W-1:0] irq_mask_word;
  reg [`SADC_DATA_W-1:0] rdata_d;

  assign wr_sel = sel_of(bus_addr);
  assign rd_sel = sel_of(bus_addr);
  assign idle = (state_q == S_IDLE);

  // start command: completion bit written as zero
  assign start_req = bus_wr && (wr_sel == SEL_STATUS) &&
    !bus_wdata[`SADC_STAT_DONE_BIT]; // [RULE_01]

  // set at the head of each slot, decide at its fixed sample phase
  assign set_bit = in_phase(state_q, phase_q, `SADC_SET_PHASE);
  assign decide = in_phase(state_q, phase_q, `SADC_SAMPLE_PHASE); // [RULE_13]

  sadc_trial_step u_step
  (
    .code(code_q),
    .bidx(bidx_q),
    .set_bit(set_bit),
    .decide(decide),
    .cmp_below(cmp_below),
    .code_next(code_step)
  );

  // sequencer next state
  always @*
  begin
    state_d = state_q;
    result_d = result_q;
    bidx_d = bidx_q;
    phase_d = phase_q;
    cyc_d = cyc_q;
    done_d = done_q;
    ev_done = 1'b0;
    ev_overrun = 1'b0;
    load_code = 1'b0;
    case (state_q)
      S_IDLE:
      begin
        if (start_req)
        begin
          state_d = S_TRIAL;
          result_d = `SADC_RESULT_RST; // [RULE_02]
          load_code = 1'b1;
          bidx_d = `SADC_TOP_BIDX; // [RULE_03]
          phase_d = 3'd0;
          cyc_d = 6'd0;
          done_d = 1'b0;
        end
      end
      S_TRIAL:
      begin
        if (start_req)
        begin
          ev_overrun = 1'b1;
        end
        cyc_d = cyc_q + 6'd1;
        if (phase_q == LAST_PHASE)
        begin
          phase_d = 3'd0;
          if (bidx_q == {`SADC_BIDX_W{1'b0}})
          begin
            state_d = S_STORE; // [RULE_05]
          end
          else
          begin
            bidx_d = bidx_q - {{(`SADC_BIDX_W-1){1'b0}}, 1'b1}; // [RULE_06]
          end
        end
        else
        begin
          phase_d = phase_q + 3'd1;
        end
      end
      S_STORE:
      begin
        if (start_req)
        begin
          ev_overrun = 1'b1;
        end
        if (cyc_q == STORE_CYC)
        begin
          result_d = code_q; // [RULE_08]
          done_d = 1'b1; // [RULE_12]
          ev_done = 1'b1; // [RULE_09]
          state_d = S_IDLE;
        end
        else
        begin
          state_d = S_IDLE;
        end
      end
      default:
      begin
        state_d = S_IDLE;
      end
    endcase
  end

  // sequencer registers
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= S_IDLE;
      bidx_q <= `SADC_TOP_BIDX;
      phase_q <= 3'd0;
      cyc_q <= 6'd0;
    end
    else
    begin
      state_q <= state_d;
      bidx_q <= bidx_d;
      phase_q <= phase_d;
      cyc_q <= cyc_d;
    end
  end

  // result and completion bit, software visible
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      result_q <= `SADC_RESULT_RST;
      done_q <= `SADC_DONE_RST;
    end
    else
    begin
      result_q <= result_d; // [RULE_02] [RULE_08]
      done_q <= done_d; // [RULE_12]
    end
  end

  // trial code toward the reference ladder
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      code_q <= `SADC_RESULT_RST;
    end
    else if (load_code)
    begin
      code_q <= `SADC_RESULT_RST; // [RULE_02]
    end
    else
    begin
      code_q <= code_step; // [RULE_04] [RULE_06]
    end
  end

  // ladder output: code n selects n/1024 of full scale
  assign trial_code = code_q; // [RULE_07]
  assign convert_active = !idle;

  // interrupt status and mask
  assign irq_clr = (bus_wr && (wr_sel == SEL_IRQ_STAT)) ?
    bus_wdata[`SADC_NUM_EV-1:0] : {`SADC_NUM_EV{1'b0}};

  sadc_irq u_irq
  (
    .clk(clk),
    .rst(rst),
    .event_set({ev_overrun, ev_done}), // [RULE_09]
    .status_clr(irq_clr),
    .mask_wr(bus_wr && (wr_sel == SEL_IRQ_MASK)),
    .mask_wdata(bus_wdata[`SADC_NUM_EV-1:0]),
    .status(irq_status),
    .mask_q(irq_mask),
    .irq(irq)
  );

  // read words, each field at its own position
  always @*
  begin
    status_word = `SADC_DATA_ZERO;
    status_word[`SADC_STAT_DONE_BIT] = done_q; // [RULE_12]
    status_word[`SADC_STAT_BUSY_BIT] = !idle;
  end

  always @*
  begin
    result_word = `SADC_DATA_ZERO;
    result_word[`SADC_RES_W-1:0] = result_q; // [RULE_08]
  end

  always @*
  begin
    trial_word = `SADC_DATA_ZERO;
    trial_word[`SADC_TRIAL_CODE_LSB +: `SADC_RES_W] = code_q;
    trial_word[`SADC_TRIAL_BIDX_LSB +: `SADC_BIDX_W] = bidx_q;
    trial_word[`SADC_TRIAL_CYC_LSB +: 6] = cyc_q;
  end

  always @*
  begin
    irq_stat_word = `SADC_DATA_ZERO;
    irq_stat_word[`SADC_NUM_EV-1:0] = irq_status; // [RULE_09]
    irq_mask_word = `SADC_DATA_ZERO;
    irq_mask_word[`SADC_NUM_EV-1:0] = irq_mask;
  end

  // read select; zero when no read strobe
  always @*
  begin
    rdata_d = `SADC_DATA_ZERO;
    if (bus_rd)
    begin
      case (rd_sel)
        SEL_STATUS: rdata_d = status_word;
        SEL_RESULT: rdata_d = result_word;
        SEL_TRIAL: rdata_d = trial_word;
        SEL_IRQ_STAT: rdata_d = irq_stat_word;
        SEL_IRQ_MASK: rdata_d = irq_mask_word;
        default: rdata_d = `SADC_DATA_ZERO;
      endcase
    end
  end

  // read data, valid the cycle after the strobe only
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bus_rdata <= `SADC_DATA_ZERO;
    end
    else
    begin
      bus_rdata <= rdata_d;
    end
  end

endmodule
`default_nettype wire

/* File: testbench/sadc_ladder_model.sv */
/* comparator and reference ladder model.
   assumes analog_input_voltage is the analog input in quarter code steps. */
`timescale 1ns/1ps
`default_nettype none
module sadc_ladder_model
(
  input wire logic [9:0] trial_code,
  input wire logic [11:0] analog_input_voltage,
  output logic cmp_below
);
  // ladder level is code/1024 of full scale, zero at code zero
  assign cmp_below = {trial_code, 2'h0} < analog_input_voltage; // equal counts as above
endmodule
`default_nettype wire

/* File: testbench/sadc_seq_chk_sva.sv */
/* port assertions for the conversion sequencer.
   assumes a bind to sadc_sequencer, one clock domain. */
`timescale 1ns/1ps
`default_nettype none
`include "sadc_consts.vh"
module sadc_seq_chk
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [31:0] bus_rdata,
  input wire logic cmp_below,
  input wire logic [9:0] trial_code,
  input wire logic convert_active,
  input wire logic irq
);
  logic [6:0] cnt_q;
  wire start_w = bus_wr && bus_addr == `SADC_OFF_STATUS && !bus_wdata[0];
  wire [9:0] bit_w = 10'h200 >> ((cnt_q - 7'h01) / 7'h06);
  wire [9:0] low_w = (bit_w << 1) - 10'h001;
  always @(posedge clk or posedge rst)
    if (rst)
      cnt_q <= 7'h00;
    else
      cnt_q <= convert_active ? cnt_q + 7'h01 : 7'h00;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  start_clear_a: assert property (start_w && !convert_active |=> convert_active && trial_code == 10'h000)
    else $error("start not taken or code not cleared");
  first_msb_a: assert property (start_w && !convert_active |=> ##1 trial_code == 10'h200)
    else $error("first trial code wrong");
  slot_set_a: assert property (convert_active && cnt_q % 7'h06 == 7'h01 |-> (trial_code & low_w) == bit_w)
    else $error("trial bit not raised");
  hi_keep_a: assert property (convert_active && cnt_q > 7'h01 && cnt_q % 7'h06 == 7'h01 |->
    (trial_code & ~low_w) == ($past(trial_code) & ~low_w)) else $error("higher bits changed");
  decide_a: assert property (convert_active && cnt_q != 7'h00 && cnt_q % 7'h06 == 7'h00 |->
    ((trial_code & bit_w) != 10'h000) == $past(cmp_below)) else $error("decision wrong");
  length_a: assert property ($fell(convert_active) |-> cnt_q == 7'h3D)
    else $error("conversion length wrong");
  hold_a: assert property (!convert_active && !start_w |=> $stable(trial_code))
    else $error("result code moved while idle");
  no_spur_a: assert property ($rose(convert_active) |-> $past(start_w))
    else $error("conversion without start");
  rdata_idle_a: assert property (!bus_rd |=> bus_rdata == 32'h0000_0000)
    else $error("read data not zero");
  mask_off_a: assert property (bus_wr && bus_addr == `SADC_OFF_IRQ_MASK && bus_wdata[1:0] == 2'h0 |=> !irq)
    else $error("irq with all masked");
  c_done: cover property ($fell(convert_active));
  c_irq: cover property ($rose(irq));
  c_keep: cover property (convert_active && cnt_q == 7'h3C && cmp_below);
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
/* self-checking bench for the conversion sequencer.
   assumes the ladder model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
`include "sadc_consts.vh"
module tb_top;
  logic clk, rst, bus_wr, bus_rd;
  logic [7:0] bus_addr;
  logic [31:0] bus_wdata, seed;
  logic [11:0] analog_input_voltage;
  wire [31:0] bus_rdata;
  wire [9:0] trial_code;
  wire cmp_below, convert_active, irq;
  int failures, num_checks, i, n;
  sadc_sequencer dut (.clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .cmp_below(cmp_below), .trial_code(trial_code),
    .convert_active(convert_active), .irq(irq));
  sadc_ladder_model adc (.trial_code(trial_code), .analog_input_voltage(analog_input_voltage), .cmp_below(cmp_below));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [31:0] sar(input logic [11:0] v);
    return (v == 12'h000) ? 32'h0000_0000 : 32'((v - 12'h001) >> 2);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_wr <= 1'h1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
    @(posedge clk);
    bus_rd <= 1'h1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd <= 1'h0;
    @(negedge clk);
    chk(bus_rdata, e, m);
  endtask
  task automatic wait_idle;
    n = 0;
    while (convert_active !== 1'h0 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    if (n == 100)
    begin
      failures++;
      $display("mismatch %0t conversion hang", $time);
      results;
    end
  endtask
  initial
  begin
    clk = 1'h0;
    forever #4 clk = ~clk; // steady fast clock
  end
  initial
  begin
    rst = 1'h1;
    bus_wr = 1'h0;
    bus_rd = 1'h0;
    bus_addr = 8'h00;
    bus_wdata = 32'h0000_0000;
    seed = 32'h0000_002B;
    analog_input_voltage = 12'h000;
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    rd(`SADC_OFF_STATUS, 32'h0000_0001, "status reset");
    rd(`SADC_OFF_RESULT, 32'h0000_0000, "result reset");
    rd(`SADC_OFF_IRQ_MASK, 32'h0000_0000, "mask reset");
    rd(8'h40, 32'h0000_0000, "unmapped");
    wr(`SADC_OFF_STATUS, 32'h0000_0001);
    rd(`SADC_OFF_STATUS, 32'h0000_0001, "no start on one");
    $display("test reset done");
    for (i = 0; i < 12; i++)
    begin
      seed = xs(seed);
      analog_input_voltage <= i == 0 ? 12'h000 : i == 1 ? 12'hFFF : i == 2 ? 12'h800 : i == 3 ? 12'h004 : seed[11:0];
      wr(`SADC_OFF_IRQ_MASK, {31'h0, i[0]});
      wr(`SADC_OFF_STATUS, 32'h0000_0000);
      rd(`SADC_OFF_STATUS, 32'h0000_0002, "busy");
      if (i == 2)
        wr(`SADC_OFF_STATUS, 32'h0000_0000);
      wait_idle; // clock kept running, no halt while busy
      rd(`SADC_OFF_RESULT, sar(analog_input_voltage), "result");
      rd(`SADC_OFF_TRIAL, sar(analog_input_voltage) | ((`SADC_CONV_CYCLES - 1) << `SADC_TRIAL_CYC_LSB), "trial word");
      rd(`SADC_OFF_STATUS, 32'h0000_0001, "done");
      chk({31'h0, irq}, {31'h0, i[0]}, "irq level");
      rd(`SADC_OFF_IRQ_STAT, i == 2 ? 32'h0000_0003 : 32'h0000_0001, "irq status");
      wr(`SADC_OFF_IRQ_STAT, 32'h0000_0003);
      @(negedge clk);
      chk({31'h0, irq}, 32'h0000_0000, "irq clear");
      $display("test %0d done", i);
    end
    results;
  end
endmodule
bind sadc_sequencer sadc_seq_chk u_chk (.clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
  .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .cmp_below(cmp_below), .trial_code(trial_code),
  .convert_active(convert_active), .irq(irq));
`default_nettype wire
